// File: rtl/mmot_consts.vh
// Constants for the management message OAM transport block
`ifndef MMOT_CONSTS_VH
`define MMOT_CONSTS_VH
// OAM code and organisation identifier (identifier value is arbitrary)
`define MMOT_OAM_CODE   8'hFE
`define MMOT_OUI        24'h5A5A5A
// Transport and PDU versions
`define MMOT_TVER       8'h01
`define MMOT_PVER       8'h01
// Transport type field
`define MMOT_TYPE_PDU   8'h00
`define MMOT_TYPE_ACK   8'h01
// Response codes
`define MMOT_RC_OK      8'h00
`define MMOT_RC_VER     8'h01
`define MMOT_RC_OOS     8'h02
`define MMOT_RC_EXCEED  8'h03
// Byte offsets inside a frame, counted from the OAM code octet
`define MMOT_OFS_CODE   9'h000
`define MMOT_OFS_OUI0   9'h001
`define MMOT_OFS_OUI1   9'h002
`define MMOT_OFS_OUI2   9'h003
`define MMOT_OFS_TVER   9'h004
`define MMOT_OFS_TYPE   9'h005
`define MMOT_OFS_SEQH   9'h006
`define MMOT_OFS_SEQL   9'h007
`define MMOT_OFS_TOTH   9'h008
`define MMOT_OFS_TOTL   9'h009
`define MMOT_OFS_LEN    9'h00A
`define MMOT_OFS_PAY    9'h00B
// First-fragment PDU header: version, reserved, message id, opcode
`define MMOT_PDU_HDR    9'h006
`define MMOT_PDU_IDH    9'h002
`define MMOT_PDU_IDL    9'h003
`define MMOT_PDU_OPH    9'h004
`define MMOT_PDU_OPL    9'h005
// Retries allowed after the first attempt
`define MMOT_MAX_RETRY  2'h3
// TCP/IP form of a message: version, id, opcode, 4-octet length; built by the host stack
`define MMOT_TCP_HDR    4'h9
`endif

// File: rtl/mmot_byte_mux.v
// Selects the outgoing frame byte for a given byte index
`timescale 1ns/1ps
`include "mmot_consts.vh"
module mmot_byte_mux (
   input  wire [8:0]  i_idx,
   input  wire        i_is_ack,
   input  wire [15:0] i_seq,
   input  wire [15:0] i_tot,
   input  wire [7:0]  i_len,
   input  wire [7:0]  i_pay,
   output reg  [7:0]  o_byte
);
   // Identifier kept at full width so each octet is a plain part-select, no silent truncation
   localparam [23:0] ORG_ID = `MMOT_OUI;

   // Header layout is fixed; payload follows at the payload offset
   always @* begin
      case (i_idx)
         `MMOT_OFS_CODE: o_byte = `MMOT_OAM_CODE;
         `MMOT_OFS_OUI0: o_byte = ORG_ID[23:16];
         `MMOT_OFS_OUI1: o_byte = ORG_ID[15:8];
         `MMOT_OFS_OUI2: o_byte = ORG_ID[7:0];
         `MMOT_OFS_TVER: o_byte = `MMOT_TVER;
         `MMOT_OFS_TYPE: o_byte = i_is_ack ? `MMOT_TYPE_ACK : `MMOT_TYPE_PDU;
         `MMOT_OFS_SEQH: o_byte = i_seq[15:8];
         `MMOT_OFS_SEQL: o_byte = i_seq[7:0];
         `MMOT_OFS_TOTH: o_byte = i_tot[15:8];
         `MMOT_OFS_TOTL: o_byte = i_tot[7:0];
         `MMOT_OFS_LEN:  o_byte = i_len;
         default:        o_byte = i_pay;
      endcase
   end
endmodule

// File: rtl/mmot_transport.v
// Management message OAM transport: fragment sender, receiver and acknowledgement engine
// What this block does
// - OAM framing used; TCP form left to host
// - Code field carries organisation-specific value 0xFE
// - Data starts with three-octet organisation identifier
// - Transport version octet is 0x01
// - Type octet: 0x00 fragment, 0x01 acknowledgement
// - Sequence number restarts for each message
// - Header carries total frame count of message
// - Length octet counts message bytes in frame
// - First fragment: six-octet PDU header, then data
// - Later fragments carry only continuation bytes
// - PDU version octet is 0x01
// - Reserved PDU octet is not interpreted
// - Opcode names command, reported; data layout not decoded here
// - Message identifier reported for response correlation
// - Every received fragment answered by one-octet code
// - Acknowledgement repeats fragment header, type acknowledgement
// - Codes: ok, version, sequence, count exceeded
// - Fragments sent in increasing sequence order
// - One fragment outstanding, wait for acknowledgement
// - Resend on timeout or non-ok code
// - Back-to-back duplicate acknowledged ok, kept once unless total count is one, then delivered again
// - Four failed attempts report control channel lost
`timescale 1ns/1ps
`include "mmot_consts.vh"
module mmot_transport (
   input  wire        i_ref_clk,
   input  wire        i_resetn,
   // Received frame bytes, starting at the OAM code octet
   input  wire        i_rx_valid,
   input  wire [7:0]  i_rx_data,
   input  wire        i_rx_last,
   // Transmitted frame bytes
   output reg         o_tx_valid,
   output reg  [7:0]  o_tx_data,
   output reg         o_tx_last,
   input  wire        i_tx_ready,
   // Message to send; fragment bytes read by index
   input  wire        i_msg_start,
   input  wire [15:0] i_msg_total,
   input  wire [7:0]  i_frag_len,
   input  wire [7:0]  i_frag_data,
   input  wire [23:0] i_ack_timeout,
   output reg  [15:0] o_tx_seq,
   output reg  [7:0]  o_frag_idx,
   output reg         o_tx_busy,
   output reg  [1:0]  o_retry_cnt,
   output reg         o_msg_sent,
   output reg         o_chan_lost,
   // Reassembled message bytes delivered to the user
   output reg         o_rx_msg_valid,
   output reg  [7:0]  o_rx_msg_data,
   output reg         o_rx_frag_done,
   output reg  [7:0]  o_rx_frag_code,
   output reg         o_rx_msg_done,
   output reg  [15:0] o_rx_msg_id,
   output reg  [15:0] o_rx_opcode
);
   localparam S_IDLE = 2'h0;
   localparam S_SEND = 2'h1;
   localparam S_WAIT = 2'h2;

   // Receive parser state
   reg  [8:0]  rx_i;
   reg         rx_drop;
   reg         rx_tver_bad;
   reg         rx_pver_bad;
   reg         rx_is_ack;
   reg  [15:0] rx_seq;
   reg  [15:0] rx_tot;
   reg  [7:0]  rx_len;
   reg  [7:0]  rx_ack_code;
   reg  [15:0] rx_exp;
   reg  [15:0] rx_last_seq;
   reg         rx_have_last;
   // Pending acknowledgement to send
   reg         ack_pend;
   reg  [15:0] ack_seq;
   reg  [15:0] ack_tot;
   reg  [7:0]  ack_len;
   reg  [7:0]  ack_code;
   // Transmit frame engine
   reg         t_act;
   reg         t_ack;
   reg  [8:0]  tidx;
   reg  [8:0]  next_tidx;
   reg  [15:0] t_seq;
   reg  [15:0] t_tot;
   reg  [7:0]  t_len;
   reg  [7:0]  t_code;
   // Sender state
   reg  [1:0]  s_st;
   reg  [15:0] s_tot;
   reg         pdu_req;
   reg  [23:0] s_timer;

   wire [8:0]  pi = rx_i - `MMOT_OFS_PAY;
   wire        rx_hdr_done = (rx_i > `MMOT_OFS_LEN);
   wire        rx_first = (rx_seq == 16'h0000);
   wire        rx_exceed = (rx_seq >= rx_tot);
   wire        rx_dup = rx_have_last && (rx_seq == rx_last_seq);
   // A fresh seq 0 restarts a message so a sender that gave up can resync
   wire        rx_take = !rx_tver_bad && !rx_exceed &&
                         ((rx_seq == rx_exp) || (!rx_dup && rx_first));
   wire        pver_now = rx_pver_bad ||
                          (rx_first && pi == 9'h000 && i_rx_data != `MMOT_PVER);
   wire        rx_pdu_byte = i_rx_valid && !rx_drop && rx_hdr_done && !rx_is_ack &&
                             (pi < {1'b0, rx_len});
   wire [7:0]  ack_rx_code = (rx_i == `MMOT_OFS_PAY) ? i_rx_data : rx_ack_code;
   reg  [7:0]  rx_code;

   // Response code for the fragment ending now; version beats count beats sequence
   always @* begin
      if (rx_tver_bad || pver_now) begin
         rx_code = `MMOT_RC_VER;
      end else if (rx_exceed) begin
         rx_code = `MMOT_RC_EXCEED;
      end else if (rx_take || rx_dup) begin
         rx_code = `MMOT_RC_OK;
      end else begin
         rx_code = `MMOT_RC_OOS;
      end
   end

   // Receive parser: header capture, data delivery, verdict at frame end
   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rx_i           <= 9'h000;
         rx_drop        <= 1'b0;
         rx_tver_bad    <= 1'b0;
         rx_pver_bad    <= 1'b0;
         rx_is_ack      <= 1'b0;
         rx_seq         <= 16'h0000;
         rx_tot         <= 16'h0000;
         rx_len         <= 8'h00;
         rx_ack_code    <= 8'h00;
         rx_exp         <= 16'h0000;
         rx_last_seq    <= 16'h0000;
         rx_have_last   <= 1'b0;
         ack_pend       <= 1'b0;
         ack_seq        <= 16'h0000;
         ack_tot        <= 16'h0000;
         ack_len        <= 8'h00;
         ack_code       <= 8'h00;
         o_rx_msg_valid <= 1'b0;
         o_rx_msg_data  <= 8'h00;
         o_rx_frag_done <= 1'b0;
         o_rx_frag_code <= 8'h00;
         o_rx_msg_done  <= 1'b0;
         o_rx_msg_id    <= 16'h0000;
         o_rx_opcode    <= 16'h0000;
      end else begin
         o_rx_msg_valid <= 1'b0;
         o_rx_frag_done <= 1'b0;
         o_rx_msg_done  <= 1'b0;
         // Taking the acknowledgement into the frame engine clears the pending flag
         if (!t_act && ack_pend && (!o_tx_valid || i_tx_ready)) begin
            ack_pend <= 1'b0;
         end
         if (i_rx_valid) begin
            rx_i <= i_rx_last ? 9'h000 : rx_i + 9'h001;
            // Header fields; frames with another code or identifier are ignored
            case (rx_i)
               `MMOT_OFS_CODE: begin
                  rx_drop     <= (i_rx_data != `MMOT_OAM_CODE);
                  rx_pver_bad <= 1'b0;
               end
               `MMOT_OFS_OUI0: if (i_rx_data != (`MMOT_OUI >> 16)) rx_drop <= 1'b1;
               `MMOT_OFS_OUI1: if (i_rx_data != ((`MMOT_OUI >> 8) & 24'h0000FF)) rx_drop <= 1'b1;
               `MMOT_OFS_OUI2: if (i_rx_data != (`MMOT_OUI & 24'h0000FF)) rx_drop <= 1'b1;
               `MMOT_OFS_TVER: rx_tver_bad <= (i_rx_data != `MMOT_TVER);
               `MMOT_OFS_TYPE: rx_is_ack <= (i_rx_data == `MMOT_TYPE_ACK);
               `MMOT_OFS_SEQH: rx_seq[15:8] <= i_rx_data;
               `MMOT_OFS_SEQL: rx_seq[7:0] <= i_rx_data;
               `MMOT_OFS_TOTH: rx_tot[15:8] <= i_rx_data;
               `MMOT_OFS_TOTL: rx_tot[7:0] <= i_rx_data;
               `MMOT_OFS_LEN:  rx_len <= i_rx_data;
               `MMOT_OFS_PAY:  rx_ack_code <= i_rx_data;
               default: ;
            endcase
         end
         // Payload of an accepted fragment; first fragment hides its PDU header
         if (rx_pdu_byte && rx_take && !pver_now) begin
            if (!rx_first || pi >= `MMOT_PDU_HDR) begin
               o_rx_msg_valid <= 1'b1;
               o_rx_msg_data  <= i_rx_data;
            end
            if (rx_first) begin
               // Reserved octet at index 1 is skipped on purpose
               case (pi)
                  `MMOT_PDU_IDH: o_rx_msg_id[15:8] <= i_rx_data;
                  `MMOT_PDU_IDL: o_rx_msg_id[7:0] <= i_rx_data;
                  `MMOT_PDU_OPH: o_rx_opcode[15:8] <= i_rx_data;
                  `MMOT_PDU_OPL: o_rx_opcode[7:0] <= i_rx_data;
                  default: ;
               endcase
            end
         end
         if (rx_pdu_byte && rx_first && pi == 9'h000 && i_rx_data != `MMOT_PVER) begin
            rx_pver_bad <= 1'b1;
         end
         // End of a fragment: answer it and advance the expected number
         if (i_rx_valid && i_rx_last && !rx_drop && rx_hdr_done && !rx_is_ack) begin
            ack_pend       <= 1'b1;
            ack_seq        <= rx_seq;
            ack_tot        <= rx_tot;
            ack_len        <= rx_len;
            ack_code       <= rx_code;
            o_rx_frag_done <= 1'b1;
            o_rx_frag_code <= rx_code;
            if (rx_take && !pver_now) begin
               rx_last_seq  <= rx_seq;
               rx_have_last <= 1'b1;
               if (rx_seq + 16'h0001 == rx_tot) begin
                  rx_exp        <= 16'h0000;
                  o_rx_msg_done <= 1'b1;
               end else begin
                  rx_exp <= rx_seq + 16'h0001;
               end
            end
         end
      end
   end

   // Acknowledgement arriving for the outstanding fragment
   wire ack_in   = i_rx_valid && i_rx_last && !rx_drop && rx_is_ack && !rx_tver_bad &&
                   (rx_i >= `MMOT_OFS_PAY) && (s_st == S_WAIT) && (rx_seq == o_tx_seq);
   wire ack_good = ack_in && (ack_rx_code == `MMOT_RC_OK);
   wire timeout  = (s_st == S_WAIT) && (s_timer >= i_ack_timeout);
   wire tx_adv   = !o_tx_valid || i_tx_ready;
   wire [8:0] t_last_idx = t_ack ? `MMOT_OFS_PAY : (`MMOT_OFS_LEN + {1'b0, t_len});
   wire [8:0] fi = next_tidx - `MMOT_OFS_PAY;
   wire [7:0] t_byte;
   wire       pdu_out_last = tx_adv && t_act && !t_ack && (tidx == t_last_idx);

   mmot_byte_mux u_mux (
      .i_idx    (tidx),
      .i_is_ack (t_ack),
      .i_seq    (t_seq),
      .i_tot    (t_tot),
      .i_len    (t_len),
      .i_pay    (t_ack ? t_code : i_frag_data),
      .o_byte   (t_byte)
   );

   // Frame index advances with each byte the link accepts
   always @* begin
      next_tidx = tidx;
      if (tx_adv) begin
         if (t_act) begin
            next_tidx = (tidx == t_last_idx) ? 9'h000 : tidx + 9'h001;
         end else begin
            next_tidx = 9'h000;
         end
      end
   end

   // Frame engine: acknowledgements go before fragments so the peer is never stalled
   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_tx_valid <= 1'b0;
         o_tx_data  <= 8'h00;
         o_tx_last  <= 1'b0;
         t_act      <= 1'b0;
         t_ack      <= 1'b0;
         tidx       <= 9'h000;
         t_seq      <= 16'h0000;
         t_tot      <= 16'h0000;
         t_len      <= 8'h00;
         t_code     <= 8'h00;
         o_frag_idx <= 8'h00;
      end else begin
         tidx       <= next_tidx;
         o_frag_idx <= fi[7:0];
         if (tx_adv) begin
            o_tx_valid <= t_act;
            o_tx_data  <= t_byte;
            o_tx_last  <= t_act && (tidx == t_last_idx);
            if (t_act && tidx == t_last_idx) begin
               t_act <= 1'b0;
            end else if (!t_act && ack_pend) begin
               t_act  <= 1'b1;
               t_ack  <= 1'b1;
               t_seq  <= ack_seq;
               t_tot  <= ack_tot;
               t_len  <= ack_len;
               t_code <= ack_code;
            end else if (!t_act && pdu_req) begin
               t_act <= 1'b1;
               t_ack <= 1'b0;
               t_seq <= o_tx_seq;
               t_tot <= s_tot;
               t_len <= i_frag_len;
            end
         end
      end
   end

   // Stop-and-wait sender with bounded retries
   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         s_st        <= S_IDLE;
         s_tot       <= 16'h0000;
         pdu_req     <= 1'b0;
         s_timer     <= 24'h000000;
         o_tx_seq    <= 16'h0000;
         o_tx_busy   <= 1'b0;
         o_retry_cnt <= 2'h0;
         o_msg_sent  <= 1'b0;
         o_chan_lost <= 1'b0;
      end else begin
         o_msg_sent  <= 1'b0;
         o_chan_lost <= 1'b0;
         s_timer     <= s_timer + 24'h000001;
         if (tx_adv && !t_act && !ack_pend && pdu_req) begin
            pdu_req <= 1'b0;
         end
         case (s_st)
            S_IDLE: begin
               if (i_msg_start && i_msg_total != 16'h0000) begin
                  s_st        <= S_SEND;
                  s_tot       <= i_msg_total;
                  o_tx_seq    <= 16'h0000;
                  o_retry_cnt <= 2'h0;
                  pdu_req     <= 1'b1;
                  o_tx_busy   <= 1'b1;
               end
            end
            S_SEND: begin
               if (pdu_out_last) begin
                  s_st    <= S_WAIT;
                  s_timer <= 24'h000000;
               end
            end
            S_WAIT: begin
               if (ack_good) begin
                  o_retry_cnt <= 2'h0;
                  if (o_tx_seq + 16'h0001 == s_tot) begin
                     s_st       <= S_IDLE;
                     o_tx_busy  <= 1'b0;
                     o_msg_sent <= 1'b1;
                  end else begin
                     s_st     <= S_SEND;
                     o_tx_seq <= o_tx_seq + 16'h0001;
                     pdu_req  <= 1'b1;
                  end
               end else if (ack_in || timeout) begin
                  if (o_retry_cnt == `MMOT_MAX_RETRY) begin
                     s_st        <= S_IDLE;
                     o_tx_busy   <= 1'b0;
                     o_chan_lost <= 1'b1;
                  end else begin
                     s_st        <= S_SEND;
                     o_retry_cnt <= o_retry_cnt + 2'h1;
                     pdu_req     <= 1'b1;
                  end
               end
            end
            default: begin
               s_st      <= S_IDLE;
               o_tx_busy <= 1'b0;
            end
         endcase
      end
   end
   // The TCP/IP form (header of `MMOT_TCP_HDR octets) is framed by the host stack, not here.
endmodule

// File: test/mmot_transport_chk.sv
// Port assertions for the management message transport block
`timescale 1ns/1ps
module mmot_chk (
   input wire        i_ref_clk,
   input wire        i_resetn,
   input wire        i_tx_ready,
   input wire        o_tx_valid,
   input wire [7:0]  o_tx_data,
   input wire        o_tx_last,
   input wire        o_tx_busy,
   input wire [15:0] o_tx_seq,
   input wire [1:0]  o_retry_cnt,
   input wire        o_chan_lost,
   input wire        o_rx_frag_done,
   input wire [7:0]  o_rx_frag_code
);
   reg [7:0] idx;
   reg       is_ack;
   // Byte position in the outgoing frame, so header octets are judged in place
   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         idx <= 8'h00;
         is_ack <= 1'b0;
      end else if (o_tx_valid && i_tx_ready) begin
         idx <= o_tx_last ? 8'h00 : idx + 8'h01;
         if (idx == 8'h05) is_ack <= o_tx_data[0];
      end
   end
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   sequence stall_s; o_tx_valid && !i_tx_ready; endsequence
   sequence held_s; o_tx_valid && $stable(o_tx_data) && $stable(o_tx_last); endsequence
   tx_hold_a: assert property (stall_s |=> held_s) else $error("tx byte changed while stalled");
   code_octet_a: assert property (o_tx_valid && idx == 8'h00 |-> o_tx_data == 8'hFE)
      else $error("bad code octet");
   org_octets_a: assert property (o_tx_valid && idx >= 8'h01 && idx <= 8'h03 |-> o_tx_data == 8'h5A)
      else $error("bad organisation octet");
   tver_octet_a: assert property (o_tx_valid && idx == 8'h04 |-> o_tx_data == 8'h01)
      else $error("bad transport version");
   type_octet_a: assert property (o_tx_valid && idx == 8'h05 |-> o_tx_data <= 8'h01)
      else $error("bad type octet");
   ack_length_a: assert property (o_tx_valid && o_tx_last && is_ack |-> idx == 8'h0B)
      else $error("ack frame not twelve bytes");
   code_range_a: assert property (o_rx_frag_done |-> o_rx_frag_code <= 8'h03)
      else $error("unknown response code");
   seq_step_a: assert property (o_tx_busy && $past(o_tx_busy) && o_tx_seq != $past(o_tx_seq)
      |-> o_tx_seq == $past(o_tx_seq) + 16'h0001) else $error("sequence skipped");
   retry_step_a: assert property (o_retry_cnt != $past(o_retry_cnt) && o_retry_cnt != 2'h0
      |-> o_retry_cnt == $past(o_retry_cnt) + 2'h1) else $error("retry count jumped");
   lost_after_a: assert property (o_chan_lost |-> $past(o_retry_cnt) == 2'h3)
      else $error("channel lost too early");
   seq_zero_a: assert property ($rose(o_tx_busy) |=> o_tx_seq == 16'h0000)
      else $error("message not started at zero");
endmodule
bind mmot_transport mmot_chk u_chk (.i_ref_clk, .i_resetn, .i_tx_ready, .o_tx_valid, .o_tx_data, .o_tx_last,
   .o_tx_busy, .o_tx_seq, .o_retry_cnt, .o_chan_lost, .o_rx_frag_done, .o_rx_frag_code);

// File: test/mmot_peer.sv
// Peer control module: takes frames from the block and sends frames into it
`timescale 1ns/1ps
`include "mmot_consts.vh"
module mmot_peer (
   input  wire       i_ref_clk,
   input  wire       i_tx_valid,
   input  wire [7:0] i_tx_data,
   input  wire       i_tx_last,
   input  wire       i_stall,
   output reg        o_tx_ready,
   output reg        o_rx_valid,
   output reg  [7:0] o_rx_data,
   output reg        o_rx_last
);
   reg [7:0] cap [0:31];
   reg [7:0] nxt [0:31];
   reg [7:0] cnt = 8'h00;
   reg [7:0] flen = 8'h00;
   reg [7:0] frames = 8'h00;
   // Flips the PDU version alone, so the transport version stays good
   reg [7:0] pver_flip = 8'h00;
   initial begin
      o_tx_ready = 1'b1;
      o_rx_valid = 1'b0;
      o_rx_data = 8'h00;
      o_rx_last = 1'b0;
   end
   // Stalling toggles ready so every byte of a frame after the first meets back-pressure
   always @(negedge i_ref_clk) o_tx_ready <= i_stall ? ~o_tx_ready : 1'b1;
   // Capture of the last frame the block sent
   always @(posedge i_ref_clk) begin
      if (i_tx_valid && o_tx_ready) begin
         cap[cnt] <= i_tx_data;
         cnt <= i_tx_last ? 8'h00 : cnt + 8'h01;
         if (i_tx_last) flen <= cnt + 8'h01;
         if (i_tx_last) frames <= frames + 8'h01;
      end
   end
   // Builds one frame and drives it a byte per cycle; seq 0 fragments get a PDU header
   task send_frame(input [7:0] ver, input [7:0] typ, input [15:0] seq, input [15:0] tot,
                   input [7:0] len, input [7:0] n, input [7:0] base);
      integer i;
      begin
         {nxt[0], nxt[1], nxt[2], nxt[3]} = {`MMOT_OAM_CODE, `MMOT_OUI};
         {nxt[4], nxt[5]} = {ver, typ};
         {nxt[6], nxt[7], nxt[8], nxt[9], nxt[10]} = {seq, tot, len};
         for (i = 0; i < n; i = i + 1) nxt[11 + i] = base + i;
         if (typ == 8'h00 && seq == 16'h0000)
            {nxt[11], nxt[12], nxt[13], nxt[14], nxt[15], nxt[16]} = {ver ^ pver_flip, 40'h7712345678};
         for (i = 0; i < 11 + n; i = i + 1) begin
            @(negedge i_ref_clk);
            o_rx_valid = 1'b1;
            o_rx_data = nxt[i];
            o_rx_last = (i == 10 + n);
         end
         @(negedge i_ref_clk);
         o_rx_valid = 1'b0;
         o_rx_last = 1'b0;
         o_rx_data = ~o_rx_data;
      end
   endtask
endmodule

// File: test/tb_mmot_transport.sv
// Self-checking bench for the management message transport block
`timescale 1ns/1ps
`include "mmot_consts.vh"
module tb_mmot_transport;
   reg         i_ref_clk = 1'b0;
   reg         i_resetn = 1'b0;
   reg         i_msg_start = 1'b0;
   reg  [15:0] i_msg_total = 16'h0000;
   reg  [7:0]  i_frag_len = 8'h00;
   reg  [23:0] i_ack_timeout = 24'h00003C;
   reg         stall = 1'b0;
   wire        rx_v, rx_l, tx_v, tx_l, tx_r, busy, sent, lost, mv, fdone, mdone;
   wire [7:0]  rx_d, tx_d, fdata, fidx, fcode, mdata;
   wire [15:0] tseq, msg_id, opcode;
   wire [1:0]  retry;
   integer     errors = 0, samples_checked = 0, cycles = 0;
   integer     delivered = 0, n_sent = 0, n_lost = 0, n_mdone = 0, last_code = 0, last_data = 0;
   always #5 i_ref_clk = ~i_ref_clk;
   // Fragment byte depends on sequence and index so misordered reads show up
   assign fdata = fidx + {tseq[3:0], 4'h0};
   mmot_transport u_dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_rx_valid(rx_v), .i_rx_data(rx_d),
      .i_rx_last(rx_l), .o_tx_valid(tx_v), .o_tx_data(tx_d), .o_tx_last(tx_l), .i_tx_ready(tx_r),
      .i_msg_start(i_msg_start), .i_msg_total(i_msg_total), .i_frag_len(i_frag_len), .i_frag_data(fdata),
      .i_ack_timeout(i_ack_timeout), .o_tx_seq(tseq), .o_frag_idx(fidx), .o_tx_busy(busy), .o_retry_cnt(retry),
      .o_msg_sent(sent), .o_chan_lost(lost), .o_rx_msg_valid(mv), .o_rx_msg_data(mdata), .o_rx_frag_done(fdone),
      .o_rx_frag_code(fcode), .o_rx_msg_done(mdone), .o_rx_msg_id(msg_id), .o_rx_opcode(opcode));
   mmot_peer u_peer (.i_ref_clk(i_ref_clk), .i_tx_valid(tx_v), .i_tx_data(tx_d), .i_tx_last(tx_l),
      .i_stall(stall), .o_tx_ready(tx_r), .o_rx_valid(rx_v), .o_rx_data(rx_d), .o_rx_last(rx_l));
   // Event tallies and the hang guard
   always @(posedge i_ref_clk) begin
      cycles = cycles + 1;
      if (mv === 1'b1) begin
         delivered = delivered + 1;
         last_data = mdata;
      end
      if (sent === 1'b1) n_sent = n_sent + 1;
      if (lost === 1'b1) n_lost = n_lost + 1;
      if (mdone === 1'b1) n_mdone = n_mdone + 1;
      if (fdone === 1'b1) last_code = fcode;
      if (cycles == 20000) begin
         errors = errors + 1;
         complete_run;
      end
   end
   task check(input [31:0] seen, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task complete_run;
      begin
         if (errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   // Bounded wait for the peer to hold a given number of frames
   task wait_frames(input [7:0] n);
      integer k;
      begin
         for (k = 0; k < 400 && u_peer.frames != n; k = k + 1) @(negedge i_ref_clk);
         check(u_peer.frames, n);
      end
   endtask
   task start_msg(input [15:0] tot, input [7:0] len);
      begin
         @(negedge i_ref_clk);
         i_msg_total = tot;
         i_frag_len = len;
         i_msg_start = 1'b1;
         @(negedge i_ref_clk);
         i_msg_start = 1'b0;
      end
   endtask
   task t_reset;
      begin
         check({busy, tx_v, lost, sent, fdone, retry}, 32'h0);
      end
   endtask
   // Two-fragment message under back-pressure, each acknowledged late
   task t_send;
      integer s, f;
      begin
         stall = 1'b1;
         f = u_peer.frames;
         start_msg(16'h0002, 8'h04);
         for (s = 0; s < 2; s = s + 1) begin
            wait_frames(f + 1);
            check(u_peer.flen, 15);
            check({u_peer.cap[0], u_peer.cap[1], u_peer.cap[2], u_peer.cap[3]}, {`MMOT_OAM_CODE, `MMOT_OUI});
            check({u_peer.cap[4], u_peer.cap[5], u_peer.cap[6], u_peer.cap[7]}, s | 32'h01000000);
            check({u_peer.cap[8], u_peer.cap[9], u_peer.cap[10]}, 24'h000204);
            check(u_peer.cap[14], 3 + 16 * s);
            repeat (10) @(negedge i_ref_clk);
            check(u_peer.frames, f + 1);
            u_peer.send_frame(8'h01, 8'h01, s, 16'h0002, 8'h04, 8'h01, `MMOT_RC_OK);
            f = f + 1;
         end
         repeat (3) @(negedge i_ref_clk);
         check({n_sent, busy}, 32'h2);
         stall = 1'b0;
      end
   endtask
   // Bad code then silence: four attempts, then the channel is reported lost
   task t_retry;
      integer f;
      begin
         f = u_peer.frames;
         start_msg(16'h0001, 8'h02);
         wait_frames(f + 1);
         u_peer.send_frame(8'h01, 8'h01, 16'h0000, 16'h0001, 8'h02, 8'h01, `MMOT_RC_OOS);
         wait_frames(f + 2);
         check({retry, u_peer.cap[7]}, 32'h100);
         wait_frames(f + 4);
         repeat (80) @(negedge i_ref_clk);
         check({n_lost, busy, u_peer.frames}, {1'b1, 1'b0, f[7:0] + 8'h04});
      end
   endtask
   // One received fragment: its code and the acknowledgement frame sent back
   task rx_one(input [7:0] ver, input [15:0] seq, input [15:0] tot, input [7:0] n, input [7:0] code);
      integer f;
      begin
         f = u_peer.frames;
         u_peer.send_frame(ver, 8'h00, seq, tot, n, n, 8'hA0);
         wait_frames(f + 1);
         check(last_code, code);
         check({u_peer.flen, u_peer.cap[5], u_peer.cap[8], u_peer.cap[9]}, {8'h0C, 8'h01, tot});
         check({u_peer.cap[6], u_peer.cap[7], u_peer.cap[10], u_peer.cap[11]}, {seq, n, code});
      end
   endtask
   task t_rx;
      begin
         rx_one(8'h01, 16'h0000, 16'h0002, 8'h08, `MMOT_RC_OK);
         check({msg_id, opcode}, 32'h12345678);
         check(delivered, 2);
         check(last_data, 8'hA7);
         rx_one(8'h01, 16'h0000, 16'h0002, 8'h08, `MMOT_RC_OK);
         check(delivered, 2);
         rx_one(8'h01, 16'h0001, 16'h0002, 8'h03, `MMOT_RC_OK);
         check(delivered, 5);
         check(last_data, 8'hA2);
         check(n_mdone, 1);
         rx_one(8'h02, 16'h0000, 16'h0004, 8'h08, `MMOT_RC_VER);
         u_peer.pver_flip = 8'h03;
         rx_one(8'h01, 16'h0000, 16'h0004, 8'h08, `MMOT_RC_VER);
         u_peer.pver_flip = 8'h00;
         rx_one(8'h01, 16'h0005, 16'h0002, 8'h08, `MMOT_RC_EXCEED);
         rx_one(8'h01, 16'h0000, 16'h0004, 8'h08, `MMOT_RC_OK);
         rx_one(8'h01, 16'h0002, 16'h0004, 8'h08, `MMOT_RC_OOS);
      end
   endtask
   initial begin
      repeat (3) @(negedge i_ref_clk);
      i_resetn = 1'b1;
      @(negedge i_ref_clk);
      t_reset;
      t_send;
      t_retry;
      t_rx;
      complete_run;
   end
endmodule
